//--- hw/nex_exec.sv
// Execution block for negate-file, multiply-W-with-file, no-operation and pop.
// Assumes the data memory answers a read combinationally in the same cycle
// and that instructions arrive with a valid strobe from the decoder.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nex_exec (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Instruction from decoder
    input  wire logic                     instr_valid_i,
    input  wire logic [15:0]              instr_i,
    // Data memory
    output logic                          mem_we_o,
    output logic [11:0]                   mem_addr_o,
    output logic [7:0]                    mem_wdata_o,
    input  wire logic [7:0]               mem_rdata_i,
    // Return stack push from the core
    input  wire logic                     push_i,
    input  wire logic [20:0]              push_data_i,
    output logic [20:0]                   return_stack_top_o,
    // Completion
    output logic                          done_o,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o
);
    import nex_pkg::*;

    // Bank and indexed address forming
    function automatic logic [11:0] nex_faddr(input logic a, input logic [7:0] f,
                                              input logic [3:0] bank, input logic ext,
                                              input logic [11:0] fsr2);
        logic [11:0] r;
        r = {bank, f};
        if (!a) begin
            if (ext && f <= NEX_IDX_LIMIT) begin
                r = fsr2 + {4'h0, f};
            end else if (f < NEX_ACC_SPLIT) begin
                r = {4'h0, f};
            end else begin
                r = {NEX_ACC_HIGH, f};
            end
        end
        return r;
    endfunction

    nex_op_type op;
    logic [7:0] w_q, w_d, bank_q, bank_d, st_q, st_d, pl_q, pl_d, ph_q, ph_d;
    logic [11:0] fsr2_q, fsr2_d;
    logic ext_q, ext_d;
    logic [20:0] stk_q [NEX_STK_DEPTH];
    logic [20:0] stk_d [NEX_STK_DEPTH];
    logic [NEX_STK_AW-1:0] sp_q, sp_d;
    nex_mem_req_type req_q, req_d;
    logic done_q, done_d, ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic [8:0] neg9;
    logic [15:0] prod;
    logic wb_hit;

    // Decode the instruction word
    always_comb begin
        op = NEX_OP_NONE;
        if (instr_valid_i) begin
            if (instr_i[15:9] == NEX_NEGATE_TOP) op = NEX_OP_NEGATE;
            else if (instr_i[15:9] == NEX_MULT_TOP) op = NEX_OP_MULT;
            else if (instr_i == NEX_POP_CODE) op = NEX_OP_POP;
            else if (instr_i == NEX_IDLE_CODE || instr_i[15:12] == NEX_IDLE_ALT) op = NEX_OP_IDLE;
        end
    end

    assign neg9   = {1'b0, ~mem_rdata_i} + 9'h001;
    assign prod   = {8'h00, w_q} * {8'h00, mem_rdata_i};
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;

    // Next state of the whole block; software writes lose to instruction effects
    always_comb begin
        w_d = w_q; bank_d = bank_q; st_d = st_q; pl_d = pl_q; ph_d = ph_q;
        fsr2_d = fsr2_q; ext_d = ext_q; sp_d = sp_q; stk_d = stk_q;
        req_d = '0; done_d = 1'b0; ack_d = wb_hit; rd_d = rd_q;
        // Memory address driven combinationally for same-cycle read data
        req_d.addr = nex_faddr(instr_i[8], instr_i[7:0], bank_q[3:0], ext_q, fsr2_q);
        // Writes land on the edge at which the master sees ack high, not before
        if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                NEX_OFS_WREG:   w_d = wb_dat_i[7:0];
                NEX_OFS_BANK:   bank_d = wb_dat_i[7:0];
                NEX_OFS_CTRL:   ext_d = wb_dat_i[0];
                NEX_OFS_STATUS: st_d = wb_dat_i[7:0];
                NEX_OFS_FSR2:   fsr2_d = {wb_dat_i[11:8] & {4{wb_sel_i[1]}}, wb_dat_i[7:0]};
                default: ;
            endcase
        end
        if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                NEX_OFS_WREG:   rd_d = {24'h0, w_q};
                NEX_OFS_BANK:   rd_d = {24'h0, bank_q};
                NEX_OFS_CTRL:   rd_d = {31'h0, ext_q};
                NEX_OFS_STATUS: rd_d = {24'h0, st_q};
                NEX_OFS_PROD:   rd_d = {16'h0, ph_q, pl_q};
                NEX_OFS_TOP:    rd_d = {11'h0, stk_q[0]};
                NEX_OFS_FSR2:   rd_d = {20'h0, fsr2_q};
                NEX_OFS_DEPTH:  rd_d = {27'h0, sp_q};
                default:        rd_d = 32'h0;
            endcase
        end
        // Push from the core shifts the stack down
        if (push_i) begin
            for (int i = NEX_STK_DEPTH - 1; i > 0; i--) stk_d[i] = stk_q[i-1];
            stk_d[0] = push_data_i;
            if (sp_q != 5'(NEX_STK_DEPTH)) sp_d = sp_q + 5'h01;
        end
        case (op)
            NEX_OP_NEGATE: begin
                req_d.we    = 1'b1;
                req_d.wdata = neg9[7:0];
                st_d[NEX_ST_N]  = neg9[7];
                st_d[NEX_ST_Z]  = (neg9[7:0] == 8'h00);
                st_d[NEX_ST_C]  = neg9[8];
                st_d[NEX_ST_HC] = ({1'b0, ~mem_rdata_i[3:0]} + 5'h01) > 5'h0F;
                st_d[NEX_ST_SW] = (mem_rdata_i == 8'h80);
                done_d = 1'b1;
            end
            NEX_OP_MULT: begin
                ph_d = prod[15:8];
                pl_d = prod[7:0];
                done_d = 1'b1;
            end
            NEX_OP_POP: begin
                for (int i = 0; i < NEX_STK_DEPTH - 1; i++) stk_d[i] = stk_q[i+1];
                stk_d[NEX_STK_DEPTH-1] = '0;
                if (sp_q != 5'h00) sp_d = sp_q - 5'h01;
                done_d = 1'b1;
            end
            NEX_OP_IDLE: done_d = 1'b1;
            default: ;
        endcase
    end

    // Register every state group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_q <= NEX_RST_BYTE; bank_q <= NEX_RST_BYTE; st_q <= NEX_RST_BYTE;
            pl_q <= NEX_RST_BYTE; ph_q <= NEX_RST_BYTE; fsr2_q <= 12'h000;
            ext_q <= 1'b0; sp_q <= '0; req_q <= '0; done_q <= 1'b0;
            ack_q <= 1'b0; rd_q <= 32'h0;
            for (int i = 0; i < NEX_STK_DEPTH; i++) stk_q[i] <= 21'h0;
        end else begin
            w_q <= w_d; bank_q <= bank_d; st_q <= st_d; pl_q <= pl_d; ph_q <= ph_d;
            fsr2_q <= fsr2_d; ext_q <= ext_d; sp_q <= sp_d; req_q <= req_d;
            done_q <= done_d; ack_q <= ack_d; rd_q <= rd_d;
            stk_q <= stk_d;
        end
    end

    // Read address must be seen by memory in the decode cycle; write is registered
    assign mem_addr_o  = req_q.we ? req_q.addr : req_d.addr;
    assign mem_we_o    = req_q.we;
    assign mem_wdata_o = req_q.wdata;
    assign return_stack_top_o = stk_q[0];
    assign done_o   = done_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;
endmodule
`default_nettype wire

//--- shared/nex_pkg.sv
// Package for the negate, pop, no-operation and multiply execution block.
// Assumes a core that presents one instruction word per cycle and a
// Wishbone master for the control and status registers.
// Operation
// - Multiply W by file byte unsigned; 16-bit product to product pair; operands kept.
// - Negate replaces the file byte with its inverse plus one, same location.
// - Negate decodes from 0110 110a ffff ffff, one word, one cycle.
// - Negate updates negative, signed wrap, carry, half carry and zero flags.
// - Bank bit zero uses access bank; one uses bank select register bank.
// - Bank bit zero with extended set: file address up to 5Fh is indexed.
// - Pop discards top of return stack, no flags changed, code 0006h, one cycle.
// - After pop the top becomes the entry pushed before the discarded one.
package nex_pkg;
    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] NEX_OFS_WREG   = 8'h00;
    localparam logic [7:0] NEX_OFS_BANK   = 8'h04;
    localparam logic [7:0] NEX_OFS_CTRL   = 8'h08;
    localparam logic [7:0] NEX_OFS_STATUS = 8'h0C;
    localparam logic [7:0] NEX_OFS_PROD   = 8'h10;
    localparam logic [7:0] NEX_OFS_TOP    = 8'h14;
    localparam logic [7:0] NEX_OFS_FSR2   = 8'h18;
    localparam logic [7:0] NEX_OFS_DEPTH  = 8'h1C;
    // Instruction patterns
    localparam logic [6:0]  NEX_NEGATE_TOP = 7'h36;  // 0110 110
    localparam logic [6:0]  NEX_MULT_TOP   = 7'h01;  // 0000 001
    localparam logic [15:0] NEX_POP_CODE   = 16'h0006;
    localparam logic [15:0] NEX_IDLE_CODE  = 16'h0000;
    localparam logic [3:0]  NEX_IDLE_ALT   = 4'hF;
    localparam logic [7:0]  NEX_IDX_LIMIT = 8'h5F;
    localparam logic [7:0]  NEX_ACC_SPLIT = 8'h60;   // Access bank low half limit
    localparam logic [3:0]  NEX_ACC_HIGH  = 4'hF;    // Upper access half bank
    // Status bit positions
    localparam int NEX_ST_C  = 0;
    localparam int NEX_ST_HC = 1;
    localparam int NEX_ST_Z  = 2;
    localparam int NEX_ST_SW = 3;
    localparam int NEX_ST_N  = 4;
    // Return stack
    localparam int NEX_STK_DEPTH = 31;
    localparam int NEX_STK_AW    = 5;
    // Reset values
    localparam logic [7:0] NEX_RST_BYTE = 8'h00;

    // Operation decoded from one instruction word
    typedef enum logic [2:0] {
        NEX_OP_NONE  = 3'b000,
        NEX_OP_NEGATE = 3'b001,
        NEX_OP_MULT   = 3'b010,
        NEX_OP_IDLE   = 3'b011,
        NEX_OP_POP   = 3'b100
    } nex_op_type;

    // Data memory access request
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } nex_mem_req_type;
endpackage

//--- testbench/nex_exec_props.sv
// Checker for the execution block, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module nex_exec_props import nex_pkg::*; (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        mem_we_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic        push_i,
    input wire logic        wb_cyc_i,
    input wire logic [20:0] return_stack_top_o,
    input wire logic        done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Decoded requests, so the properties stay short
    logic neg, pop, idle, mul;
    assign neg  = instr_valid_i && instr_i[15:9] == NEX_NEGATE_TOP;
    assign pop  = instr_valid_i && instr_i == NEX_POP_CODE;
    assign idle = instr_valid_i && (instr_i == NEX_IDLE_CODE || instr_i[15:12] == NEX_IDLE_ALT);
    assign mul  = instr_valid_i && instr_i[15:9] == NEX_MULT_TOP;
    chk_negate_value: assert property (neg |=> mem_we_o && mem_wdata_o == (~$past(mem_rdata_i)) + 8'h01)
        else $error("negate wrote a wrong byte");
    chk_negate_bank: assert property (neg && instr_i[8] |=> mem_addr_o[7:0] == $past(instr_i[7:0]))
        else $error("banked negate used a wrong address");
    chk_negate_once: assert property (neg |=> ##1 !mem_we_o)
        else $error("negate wrote for more than one cycle");
    chk_pop_quiet: assert property (pop |=> done_o && !mem_we_o)
        else $error("pop did not finish cleanly");
    chk_top_hold: assert property (!push_i && !pop && !wb_cyc_i |=> $stable(return_stack_top_o))
        else $error("stack top moved without cause");
    chk_idle_quiet: assert property (idle |=> done_o && !mem_we_o)
        else $error("no-operation touched memory");
    chk_mul_quiet: assert property (mul |=> done_o && !mem_we_o)
        else $error("multiply wrote its operand");
    chk_done_cause: assert property (done_o |-> $past(instr_valid_i))
        else $error("done without an instruction");
endmodule
bind nex_exec nex_exec_props u_props (.*);
`default_nettype wire

//--- testbench/test_nex_exec.sv
// Self-checking bench for the execution block; the bench plays memory, core and bus master.
`timescale 1ns/1ps
`default_nettype none
module test_nex_exec;
    import nex_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, push_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, mem_we_o, done_o, wb_ack_o;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0]  mem_rdata_i = 8'h00, wb_adr_i = 8'h00, mem_wdata_o;
    logic [20:0] push_data_i = 21'h000000, return_stack_top_o;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [11:0] mem_addr_o, ad;
    int          num_errors = 0, checks = 0;
    nex_exec uut (.*);
    initial forever #12.5 clk_i = ~clk_i;
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    // One instruction; address sampled while presented, results in the next cycle
    task automatic run(input logic [15:0] i, input logic [7:0] d);
        @(posedge clk_i);
        {instr_valid_i, instr_i, mem_rdata_i} <= {1'b1, i, d};
        #1 ad = mem_addr_o;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task automatic neg(input logic [15:0] i, input logic [7:0] d, input logic [11:0] a,
                       input logic [7:0] r, input logic [7:0] st);
        run(i, d);
        compare(ad, a);
        compare({mem_we_o, done_o, mem_wdata_o}, {2'b11, r});
        wb(1'b0, NEX_OFS_STATUS, 0);
        compare(rd, st);
    endtask
    task automatic test_negate;
        wb(1'b1, NEX_OFS_BANK, 32'h3);
        neg(16'h6D20, 8'h3A, 12'h320, 8'hC6, 8'h10);
        neg(16'h6C00, 8'h00, 12'h000, 8'h00, 8'h07);
        neg(16'h6C70, 8'h80, 12'hF70, 8'h80, 8'h1A);
        wb(1'b1, NEX_OFS_FSR2, 32'h100);
        wb(1'b1, NEX_OFS_CTRL, 32'h1);
        neg(16'h6C5F, 8'h80, 12'h15F, 8'h80, 8'h1A);
        neg(16'h6C60, 8'h80, 12'hF60, 8'h80, 8'h1A);
        $display("test_negate done");
    endtask
    task automatic test_multiply;
        wb(1'b1, NEX_OFS_WREG, 32'hC4);
        run(16'h03B5, 8'hB5);
        compare({mem_we_o, done_o}, 2'b01);
        wb(1'b0, NEX_OFS_PROD, 0);
        compare(rd, 32'h8A94);
        wb(1'b0, NEX_OFS_WREG, 0);
        compare(rd, 32'hC4);
        $display("test_multiply done");
    endtask
    // Pop, then no-operation in both forms; flags must stay put
    task automatic test_pop_nop;
        @(posedge clk_i);
        {push_i, push_data_i} <= {1'b1, 21'h0031A2};
        @(posedge clk_i);
        push_data_i <= 21'h014332;
        @(posedge clk_i);
        push_i <= 1'b0;
        run(NEX_POP_CODE, 8'h00);
        compare({mem_we_o, done_o, return_stack_top_o}, {2'b01, 21'h0031A2});
        run(16'h0000, 8'h00);
        compare({mem_we_o, done_o}, 2'b01);
        run(16'hF123, 8'h00);
        compare({mem_we_o, done_o}, 2'b01);
        wb(1'b0, NEX_OFS_STATUS, 0);
        compare(rd, 32'h1A);
        wb(1'b0, 8'h20, 0);
        compare(rd, 32'h0);
        $display("test_pop_nop done");
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        test_negate();
        test_multiply();
        test_pop_nop();
        complete_run();
    end
endmodule
`default_nettype wire
